// File: core/nad_pkg.sv
// Package: types and constants for the nibble add datapath
package nad_pkg;

    // ------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------
    localparam int NIB_W   = 4;
    localparam int INSN_W  = 10;
    localparam int PTR_W   = 6;
    localparam int IMM_LSB = 0;

    // Opcode for add-immediate: upper six bits 000110
    localparam logic [5:0] ADD_IMM_OPC = 6'h06;
    // Full-word opcodes for the memory adds
    localparam logic [9:0] ADD_MEM_OPC   = 10'h00A;
    localparam logic [9:0] ADD_MEMC_OPC  = 10'h00B;

    // Reset values
    localparam logic [3:0] ACC_RST   = 4'h0;
    localparam logic       CARRY_RST = 1'b0;

    typedef enum logic [1:0]
    {
        NAD_OP_NONE = 2'b00,
        NAD_OP_IMM  = 2'b01,
        NAD_OP_MEM  = 2'b11,
        NAD_OP_MEMC = 2'b10
    } nad_op_t;

    // Instruction issue from the sequencer
    typedef struct packed
    {
        logic                valid;
        logic [INSN_W-1:0]   word;
    } nad_issue_t;

    // Datapath results
    typedef struct packed
    {
        logic [NIB_W-1:0] acc;
        logic             carry_flag;
        logic             skip;
        logic             done;
    } nad_result_t;

    // State of the top module apart from the pointer copy
    typedef struct packed
    {
        logic [NIB_W-1:0] acc;
        logic             carry_flag;
        logic             skip;
        logic             done;
    } nad_state_t;

endpackage : nad_pkg

// File: core/nad_adder.sv
// Adder: 4-bit sum with carry in and carry out
`timescale 1ns/10ps
module nad_adder
#(
    parameter int W = 4
)
(
    // Operands
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         cin,
    // Result
    output logic      [W-1:0] sum,
    output logic              cout
);
    always_comb
    begin
        {cout, sum} = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    end
endmodule : nad_adder

// File: core/nad_datapath.sv
// Top: accumulator add datapath with carry flag and skip request
`timescale 1ns/10ps
module nad_datapath
    import nad_pkg::*;
#(
    parameter int DPW = nad_pkg::PTR_W
)
(
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    // Instruction issue
    input  wire nad_pkg::nad_issue_t      ISSUE,
    // Memory nibble at the data pointer
    input  wire logic [DPW-1:0]           DATA_POINTER,
    input  wire logic [nad_pkg::NIB_W-1:0] MEM_NIBBLE,
    // Results
    output nad_pkg::nad_result_t          RESULT,
    output logic [DPW-1:0]                MEM_ADDR
);
    import nad_pkg::*;

    // ------------------------------------------------------------
    // Register image
    // ------------------------------------------------------------
    // Pointer copy shares the one state register with the datapath
    typedef struct packed
    {
        nad_state_t     core;
        logic [DPW-1:0] ptr;
    } nad_regs_t;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_imm_add
    (
        input logic [INSN_W-1:0] w
    );
        return w[INSN_W-1:NIB_W] == ADD_IMM_OPC;
    endfunction : is_imm_add

    function automatic logic is_mem_add
    (
        input logic [INSN_W-1:0] w
    );
        return w == ADD_MEM_OPC;
    endfunction : is_mem_add

    function automatic logic is_memc_add
    (
        input logic [INSN_W-1:0] w
    );
        return w == ADD_MEMC_OPC;
    endfunction : is_memc_add

    // Opcode classes are disjoint, so the order below is free
    function automatic nad_op_t decode
    (
        input logic              vld,
        input logic [INSN_W-1:0] w
    );
        nad_op_t o;
        o = NAD_OP_NONE;
        if (!vld)
            o = NAD_OP_NONE;
        else if (is_imm_add(w))
            o = NAD_OP_IMM;
        else if (is_mem_add(w))
            o = NAD_OP_MEM;
        else if (is_memc_add(w))
            o = NAD_OP_MEMC;
        return o;
    endfunction : decode

    // Only the with-carry add reads and writes the carry flag
    function automatic logic uses_carry
    (
        input nad_op_t o
    );
        return o == NAD_OP_MEMC;
    endfunction : uses_carry

    // Every decoded add writes the accumulator and pulses done
    function automatic logic writes_acc
    (
        input nad_op_t o
    );
        return o != NAD_OP_NONE;
    endfunction : writes_acc

    // Skip only follows an immediate add that did not overflow
    function automatic logic skip_next
    (
        input nad_op_t o,
        input logic    co
    );
        return (o == NAD_OP_IMM) && !co;
    endfunction : skip_next

    // State and result share a layout; copied field by field
    function automatic nad_result_t to_result
    (
        input nad_state_t s
    );
        nad_result_t r;
        r.acc        = s.acc;
        r.carry_flag = s.carry_flag;
        r.skip       = s.skip;
        r.done       = s.done;
        return r;
    endfunction : to_result

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    nad_regs_t            regs_q;
    nad_regs_t            regs_d;
    nad_op_t              op;
    logic                 imm_sel;
    wire  [NIB_W-1:0]     operand;
    logic                 cin;
    logic [NIB_W-1:0]     sum;
    logic                 cout;

    // ------------------------------------------------------------
    // Operand select
    // ------------------------------------------------------------
    always_comb
    begin
        op      = decode(ISSUE.valid, ISSUE.word);
        imm_sel = (op == NAD_OP_IMM);
        // Forced low so the plain adds never see the flag
        cin     = uses_carry(op) ? regs_q.core.carry_flag : 1'b0;
    end

    // One mux per operand bit: immediate field or memory nibble
    for (genvar i = 0; i < NIB_W; i++)
    begin : g_operand
        assign operand[i] = imm_sel
                          ? ISSUE.word[IMM_LSB + i]
                          : MEM_NIBBLE[i];
    end

    // ------------------------------------------------------------
    // Adder
    // ------------------------------------------------------------
    nad_adder #(.W(NIB_W)) u_add
    (
        .a    (regs_q.core.acc),
        .b    (operand),
        .cin  (cin),
        .sum  (sum),
        .cout (cout)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        regs_d           = regs_q;
        regs_d.ptr       = DATA_POINTER;
        regs_d.core.skip = skip_next(op, cout);
        regs_d.core.done = writes_acc(op);
        case (op)
            NAD_OP_IMM:
            begin
                // Carry flag deliberately left as it was
                regs_d.core.acc = sum;
            end
            NAD_OP_MEM:
            begin
                regs_d.core.acc = sum;
            end
            NAD_OP_MEMC:
            begin
                regs_d.core.acc = sum;
            end
            default:
            begin
                regs_d.core.acc = regs_q.core.acc;
            end
        endcase
        if (uses_carry(op))
        begin
            regs_d.core.carry_flag = cout;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            regs_q.core.acc        <= ACC_RST;
            regs_q.core.carry_flag <= CARRY_RST;
            regs_q.core.skip       <= 1'b0;
            regs_q.core.done       <= 1'b0;
            regs_q.ptr             <= '0;
        end
        else
        begin
            regs_q <= regs_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pointer copy is one cycle late: address the memory from
    // DATA_POINTER itself when the nibble is needed in this cycle
    always_comb
    begin
        RESULT   = to_result(regs_q.core);
        MEM_ADDR = regs_q.ptr;
    end

endmodule : nad_datapath

// File: tb/nad_sva.sv
// Checker: port assertions for the nibble add datapath
`timescale 1ns/10ps
module nad_sva
    import nad_pkg::*;
(
    input wire logic                  CLK,
    input wire logic                  RSTN,
    input wire nad_pkg::nad_issue_t   ISSUE,
    input wire logic [NIB_W-1:0]      MEM_NIBBLE,
    input wire nad_pkg::nad_result_t  RESULT
);
    wire imm_op  = ISSUE.valid && ISSUE.word[9:4] == ADD_IMM_OPC;
    wire mem_op  = ISSUE.valid && ISSUE.word == ADD_MEM_OPC;
    wire memc_op = ISSUE.valid && ISSUE.word == ADD_MEMC_OPC;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    a_imm_sum: assert property (imm_op |=> RESULT.done &&
        RESULT.acc == $past(RESULT.acc) + 4'($past(ISSUE.word)))
        else $error("imm sum wrong");
    a_imm_carry: assert property (imm_op |=>
        $stable(RESULT.carry_flag)) else $error("imm carry moved");
    a_imm_skip: assert property (imm_op |=> RESULT.skip ==
        ($past(RESULT.acc) + 4'($past(ISSUE.word)) < 5'h10))
        else $error("imm skip wrong");
    a_mem_add: assert property (mem_op |=>
        $stable(RESULT.carry_flag) &&
        RESULT.acc == $past(RESULT.acc) + $past(MEM_NIBBLE))
        else $error("mem add wrong");
    a_memc_add: assert property (memc_op |=> {RESULT.carry_flag,
        RESULT.acc} == $past(RESULT.acc) + $past(MEM_NIBBLE)
        + $past(RESULT.carry_flag)) else $error("memc add wrong");
    a_skip_only: assert property (!imm_op |=> !RESULT.skip)
        else $error("stray skip");
endmodule : nad_sva
bind nad_datapath nad_sva u_sva (.CLK(CLK), .RSTN(RSTN), .ISSUE(ISSUE),
    .MEM_NIBBLE(MEM_NIBBLE), .RESULT(RESULT));

// File: tb/test_nibble_add_datapath.sv
// Testbench: corner and random instructions against a reference model
`timescale 1ns/10ps
module test_nibble_add_datapath;
    import nad_pkg::*;
    logic        clk = 0;
    logic        rstn = 0;
    nad_issue_t  issue = '0;
    logic [5:0]  ptr = '0;
    logic [5:0]  ptr_q = '0;
    logic [3:0]  mem = '0;
    nad_result_t res;
    nad_result_t ex;
    logic [5:0]  maddr;
    int          errors = 0;
    int          num_checks = 0;
    localparam logic [9:0] CORNER [6] =
        '{10'h063, 10'h062, 10'h00B, 10'h06F, 10'h00A, 10'h06F};
    always #4 clk = ~clk;
    nad_datapath DUT (.CLK(clk), .RSTN(rstn), .ISSUE(issue),
        .DATA_POINTER(ptr), .MEM_NIBBLE(mem), .RESULT(res), .MEM_ADDR(maddr));
    function automatic nad_result_t nxt(nad_result_t r, nad_issue_t i,
                                        logic [3:0] m);
        logic [4:0] s;
        nxt = '{r.acc, r.carry_flag, 1'b0, 1'b0};
        if (!i.valid)
            return nxt;
        s = r.acc + m + (i.word == ADD_MEMC_OPC ? r.carry_flag : 1'b0);
        if (i.word[9:4] == ADD_IMM_OPC)
            s = r.acc + i.word[3:0];
        nxt.done = i.word[9:4] == ADD_IMM_OPC || i.word == ADD_MEM_OPC
            || i.word == ADD_MEMC_OPC;
        nxt.skip = i.word[9:4] == ADD_IMM_OPC && !s[4];
        if (nxt.done)
            nxt.acc = s[3:0];
        if (i.word == ADD_MEMC_OPC)
            nxt.carry_flag = s[4];
    endfunction : nxt
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic check_outputs;
        chk("acc", 8'(res.acc), 8'(ex.acc));
        chk("carry", 8'(res.carry_flag), 8'(ex.carry_flag));
        chk("skip", 8'(res.skip), 8'(ex.skip));
        chk("done", 8'(res.done), 8'(ex.done));
        chk("mem_addr", 8'(maddr), 8'(ptr_q));
    endtask : check_outputs
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial
    begin
        void'($urandom(32'hDAC53579));
        ex = '0;
        repeat (10) @(posedge clk);
        #1 rstn = 1;
        for (int k = 0; k < 600; k++)
        begin
            @(posedge clk);
            #1;
            check_outputs();
            case ($urandom_range(3))
                0: issue.word = {ADD_IMM_OPC, 4'($urandom)};
                1: issue.word = ADD_MEM_OPC;
                2: issue.word = ADD_MEMC_OPC;
                default: issue.word = 10'($urandom);
            endcase
            if (k < 6)
                issue.word = CORNER[k];
            issue.valid = k < 6 || $urandom_range(4) != 0;
            // Pointer copy shows the value driven before the next edge
            ptr = 6'($urandom);
            ptr_q = ptr;
            // Full nibble in the corners forces carries and overflows
            mem = (k < 6) ? 4'hF : 4'($urandom);
            ex = nxt(ex, issue, mem);
        end
        // The last instruction lands one edge after the loop
        @(posedge clk);
        #1;
        check_outputs();
        $display("random instruction test done");
        final_report();
    end
endmodule : test_nibble_add_datapath
